// ==== rtl/pio_pkg.sv ====
// Package for the parallel I/O controller: register offsets, reset values, widths.
// Assumes a 32-bit APB register bus with word-aligned byte addresses.
package pio_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_OWN_EN = 8'h00;
  localparam logic [7:0] OFF_OWN_DIS = 8'h04;
  localparam logic [7:0] OFF_OWN_STAT = 8'h08;
  localparam logic [7:0] OFF_DRV_EN = 8'h10;
  localparam logic [7:0] OFF_DRV_DIS = 8'h14;
  localparam logic [7:0] OFF_DRV_STAT = 8'h18;
  localparam logic [7:0] OFF_DG_EN = 8'h20;
  localparam logic [7:0] OFF_DG_DIS = 8'h24;
  localparam logic [7:0] OFF_DG_STAT = 8'h28;
  localparam logic [7:0] OFF_LVL_SET = 8'h30;
  localparam logic [7:0] OFF_LVL_CLR = 8'h34;
  localparam logic [7:0] OFF_DRIVEN = 8'h38;
  localparam logic [7:0] OFF_PIN = 8'h3C;
  localparam logic [7:0] OFF_IRQ_EN = 8'h40;
  localparam logic [7:0] OFF_IRQ_DIS = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFF_IRQ_PEND = 8'h4C;
  localparam logic [7:0] OFF_OD_EN = 8'h50;
  localparam logic [7:0] OFF_OD_DIS = 8'h54;
  localparam logic [7:0] OFF_OD_STAT = 8'h58;
  localparam logic [7:0] OFF_PU_DIS = 8'h60;
  localparam logic [7:0] OFF_PU_EN = 8'h64;
  localparam logic [7:0] OFF_PU_STAT = 8'h68;
  localparam logic [7:0] OFF_SEL_A = 8'h70;
  localparam logic [7:0] OFF_SEL_B = 8'h74;
  localparam logic [7:0] OFF_SEL_STAT = 8'h78;
  localparam logic [7:0] OFF_DW_EN = 8'hA0;
  localparam logic [7:0] OFF_DW_DIS = 8'hA4;
  localparam logic [7:0] OFF_DW_MASK = 8'hA8;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_OWN = 32'hFFFF_FFFF;
endpackage : pio_pkg

// ==== rtl/pio_glitch_filter.sv ====
// Per-line input glitch filter working on both clock edges.
// Assumes pin inputs are synchronous to core_clk and an enable from the power manager.
`timescale 1ns/100ps
`default_nettype none
module pio_glitch_filter #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] filt_out
);
  // A level must be seen on the falling edge and again on the rising edge to pass:
  // shorter than half a cycle is never seen twice, one and a half cycles always is.
  logic [WIDTH-1:0] fall_r;
  logic [WIDTH-1:0] agree_r;

  always_ff @(negedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_r <= WIDTH'(pio_pkg::RST_ZERO);
    end else if (clk_en) begin
      fall_r <= pin_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      agree_r <= WIDTH'(pio_pkg::RST_ZERO);
    end else if (clk_en) begin
      // Change before a falling edge shows at the next rise; before a rise, one cycle later.
      // Each line is judged on its own, so a busy neighbour never holds back a quiet line.
      agree_r <= (pin_in & ~(fall_r ^ pin_in)) | (agree_r & (fall_r ^ pin_in));
    end
  end

  assign filt_out = agree_r;
endmodule // pio_glitch_filter
`default_nettype wire

// ==== rtl/pio_ctrl.sv ====
// Parallel I/O controller: APB register bank, pin drive, input filtering, change interrupt.
// Assumes pins synchronous to core_clk and periph_clk_en from the power manager.
`timescale 1ns/100ps
`default_nettype none
module pio_ctrl #(
  parameter logic [31:0] LINES_PRESENT = 32'hFFFF_FFFF,
  parameter logic [31:0] LINES_MUXED = 32'hFFFF_FFFF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic periph_clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic [31:0] pin_pullup_en,
  input wire logic [31:0] periph_a_out,
  input wire logic [31:0] periph_a_oe,
  input wire logic [31:0] periph_b_out,
  input wire logic [31:0] periph_b_oe,
  output logic [31:0] periph_in,
  output logic irq
);
  logic [31:0] own_r;
  logic [31:0] drive_r;
  logic [31:0] dg_r;
  logic [31:0] level_r;
  logic [31:0] mask_r;
  logic [31:0] pend_r;
  logic [31:0] od_r;
  logic [31:0] pu_r;
  logic [31:0] sel_r;
  logic [31:0] dw_r;
  logic [31:0] filt;
  logic [31:0] sampled;
  logic [31:0] last_r;
  logic [31:0] rdata_nxt;
  logic [31:0] change;
  logic [31:0] wmask;
  logic wr;
  logic rd;
  logic mapped;
  logic setup;
  logic access;
  logic [31:0] steer_out;
  logic [31:0] steer_oe;

  function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] s,
                                          input logic [31:0] c);
    set_clr = (cur | s) & ~c;
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign wmask = pwdata & LINES_PRESENT;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  pio_glitch_filter #(
    .WIDTH(32)
  ) u_filter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(periph_clk_en),
    .pin_in(pin_in),
    .filt_out(filt)
  );

  assign sampled = (dg_r & filt) | (~dg_r & pin_in);

  // Ownership: unmultiplexed lines stay with the controller whatever is written.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      own_r <= pio_pkg::RST_OWN;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_OWN_EN)) begin
        own_r <= set_clr(own_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_OWN_DIS)) begin
        own_r <= set_clr(own_r, 32'h0000_0000, wmask & LINES_MUXED);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_DRV_EN)) begin
        drive_r <= set_clr(drive_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_DRV_DIS)) begin
        drive_r <= set_clr(drive_r, 32'h0000_0000, wmask);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dg_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_DG_EN)) begin
        dg_r <= set_clr(dg_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_DG_DIS)) begin
        dg_r <= set_clr(dg_r, 32'h0000_0000, wmask);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_LVL_SET)) begin
        level_r <= set_clr(level_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_LVL_CLR)) begin
        level_r <= set_clr(level_r, 32'h0000_0000, wmask);
      end else if (hit(paddr, pio_pkg::OFF_DRIVEN)) begin
        level_r <= (level_r & ~(dw_r & LINES_PRESENT)) | (wmask & dw_r);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_IRQ_EN)) begin
        mask_r <= set_clr(mask_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_IRQ_DIS)) begin
        mask_r <= set_clr(mask_r, 32'h0000_0000, wmask);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      od_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_OD_EN)) begin
        od_r <= set_clr(od_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_OD_DIS)) begin
        od_r <= set_clr(od_r, 32'h0000_0000, wmask);
      end
    end
  end

  // A set status bit means the pull-up is off, so the pull-up enable register clears it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pu_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_PU_DIS)) begin
        pu_r <= set_clr(pu_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_PU_EN)) begin
        pu_r <= set_clr(pu_r, 32'h0000_0000, wmask);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_SEL_A)) begin
        sel_r <= set_clr(sel_r, 32'h0000_0000, wmask);
      end else if (hit(paddr, pio_pkg::OFF_SEL_B)) begin
        sel_r <= set_clr(sel_r, wmask, 32'h0000_0000);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dw_r <= pio_pkg::RST_ZERO;
    end else if (wr) begin
      if (hit(paddr, pio_pkg::OFF_DW_EN)) begin
        dw_r <= set_clr(dw_r, wmask, 32'h0000_0000);
      end else if (hit(paddr, pio_pkg::OFF_DW_DIS)) begin
        dw_r <= set_clr(dw_r, 32'h0000_0000, wmask);
      end
    end
  end

  // Samples freeze while the clock is gated off, so readback holds the last levels.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_r <= pio_pkg::RST_ZERO;
    end else if (periph_clk_en) begin
      last_r <= sampled & LINES_PRESENT;
    end
  end

  // Every line is compared, whether owned or given to a peripheral.
  assign change = periph_clk_en ? ((sampled & LINES_PRESENT) ^ last_r) : 32'h0000_0000;

  // A change in the same cycle as the clearing read survives: set wins.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= pio_pkg::RST_ZERO;
    end else if (rd && hit(paddr, pio_pkg::OFF_IRQ_PEND)) begin
      // Only the bits handed out at setup are cleared, so a change caught since is kept.
      pend_r <= (pend_r & ~prdata) | change;
    end else begin
      pend_r <= pend_r | change;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(pend_r & mask_r);
    end
  end

  // Output steering: controller when owned, else the selected peripheral.
  always_comb begin
    steer_out = 32'h0000_0000;
    steer_oe = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (own_r[i]) begin
        steer_out[i] = level_r[i];
        steer_oe[i] = drive_r[i];
      end else if (sel_r[i]) begin
        steer_out[i] = periph_b_out[i];
        steer_oe[i] = periph_b_oe[i];
      end else begin
        steer_out[i] = periph_a_out[i];
        steer_oe[i] = periph_a_oe[i];
      end
    end
  end

  // Open-drain lines only ever pull low, so their enable follows the inverted level.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= pio_pkg::RST_ZERO;
    end else begin
      pin_out <= steer_out & ~od_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe <= pio_pkg::RST_ZERO;
    end else begin
      pin_oe <= LINES_PRESENT & steer_oe & ~(od_r & steer_out);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_pullup_en <= pio_pkg::RST_ZERO;
    end else begin
      pin_pullup_en <= ~pu_r & LINES_PRESENT;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_in <= pio_pkg::RST_ZERO;
    end else begin
      periph_in <= pin_in;
    end
  end

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      pio_pkg::OFF_OWN_STAT: rdata_nxt = own_r | ~LINES_MUXED;
      pio_pkg::OFF_DRV_STAT: rdata_nxt = drive_r;
      pio_pkg::OFF_DG_STAT: rdata_nxt = dg_r;
      pio_pkg::OFF_DRIVEN: rdata_nxt = level_r;
      pio_pkg::OFF_PIN: rdata_nxt = last_r;
      pio_pkg::OFF_IRQ_MASK: rdata_nxt = mask_r;
      pio_pkg::OFF_IRQ_PEND: rdata_nxt = pend_r;
      pio_pkg::OFF_OD_STAT: rdata_nxt = od_r;
      pio_pkg::OFF_PU_STAT: rdata_nxt = pu_r;
      pio_pkg::OFF_SEL_STAT: rdata_nxt = sel_r;
      pio_pkg::OFF_DW_MASK: rdata_nxt = dw_r;
      pio_pkg::OFF_OWN_EN, pio_pkg::OFF_OWN_DIS, pio_pkg::OFF_DRV_EN,
      pio_pkg::OFF_DRV_DIS, pio_pkg::OFF_DG_EN, pio_pkg::OFF_DG_DIS,
      pio_pkg::OFF_LVL_SET, pio_pkg::OFF_LVL_CLR, pio_pkg::OFF_IRQ_EN,
      pio_pkg::OFF_IRQ_DIS, pio_pkg::OFF_OD_EN, pio_pkg::OFF_OD_DIS,
      pio_pkg::OFF_PU_DIS, pio_pkg::OFF_PU_EN, pio_pkg::OFF_SEL_A,
      pio_pkg::OFF_SEL_B, pio_pkg::OFF_DW_EN, pio_pkg::OFF_DW_DIS: rdata_nxt = 32'h0000_0000;
      default: begin
        rdata_nxt = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  // Read data is registered in the setup cycle, so every access completes in two cycles.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= pio_pkg::RST_ZERO;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : (rdata_nxt & LINES_PRESENT);
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end
endmodule // pio_ctrl
`default_nettype wire

// ==== test/pio_ctrl_monitor.sv ====
// Port checker for the parallel I/O controller, bound into pio_ctrl.
// Assumes one clock domain, core_clk, with rst_b as its asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module pio_ctrl_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic periph_clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] periph_in,
  input wire logic irq
);
  logic setup, rd_pend, wr_dis, wr_en;
  logic [31:0] pin_d_r;
  logic [2:0] quiet_r;
  assign setup = psel && !penable;
  assign rd_pend = psel && penable && pready && !pwrite && paddr == pio_pkg::OFF_IRQ_PEND;
  assign wr_dis = psel && penable && pready && pwrite && paddr == pio_pkg::OFF_IRQ_DIS;
  assign wr_en = psel && penable && pready && pwrite && paddr == pio_pkg::OFF_IRQ_EN;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) pin_d_r <= '0;
    else pin_d_r <= pin_in;
  end
  // Counts quiet cycles so a pending read is only judged once no change is still in flight.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) quiet_r <= '0;
    else if (pin_in != pin_d_r || !periph_clk_en) quiet_r <= '0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_READY_AFTER_SETUP: assert property (setup |=> pready)
    else $error("pready missing after setup");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_UNMAPPED_ERR: assert property (setup && paddr == 8'h0C |=> pslverr && prdata == 32'h0)
    else $error("reserved offset not refused");
  AST_MAPPED_OK: assert property (setup && paddr == pio_pkg::OFF_PIN |=> !pslverr)
    else $error("mapped offset refused");
  AST_PERIPH_RAW: assert property ($past(rst_b) && $past(periph_clk_en) |-> periph_in == $past(pin_in))
    else $error("peripheral input not a plain copy of the pins");
  AST_PEND_READ_CLEARS: assert property (rd_pend && quiet_r >= 3'h3 |=> ##1 !irq)
    else $error("irq stays after pending read");
  AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |-> $past(rd_pend, 2) || $past(wr_dis, 2))
    else $error("irq dropped without read or disable");
  AST_IRQ_RISE_CAUSE: assert property ($rose(irq) |-> $past(periph_clk_en, 2) || $past(wr_en, 2))
    else $error("irq raised with clock off");
  COV_PEND_READ: cover property (rd_pend && irq);
  COV_IRQ_RISE: cover property ($rose(irq));
  COV_PIN_READ: cover property (setup && paddr == pio_pkg::OFF_PIN);
endmodule // pio_ctrl_monitor
bind pio_ctrl pio_ctrl_monitor u_mon (.core_clk(core_clk), .rst_b(rst_b),
  .periph_clk_en(periph_clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pin_in(pin_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_in(periph_in), .irq(irq));
`default_nettype wire

// ==== test/pin_partner.sv ====
// External pins: each line takes the controller drive where enabled, else the bench level.
// Assumes bench levels change just after a rising edge; glitches are made here.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input wire logic core_clk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_lvl,
  input wire logic [31:0] glitch,
  output logic [31:0] pin_in
);
  logic [31:0] g_r = 32'h0;
  // A 3.5 ns pulse across the falling edge is under half a cycle, so it must vanish.
  always @(posedge core_clk) begin
    if (glitch != 32'h0) begin
      #1 g_r = glitch;
      #3.5 g_r = 32'h0;
    end
  end
  assign pin_in = ((pin_oe & pin_out) | (~pin_oe & ext_lvl)) ^ g_r;
endmodule // pin_partner
`default_nettype wire

// ==== test/test_parallel_io_input_and_register_map.sv ====
// Self-checking bench: register bank over APB, pin readback, filter and change detection.
// Assumes pin_partner resolves the lines and pio_ctrl_monitor is bound to the design.
`timescale 1ns/100ps
`default_nettype none
module test_parallel_io_input_and_register_map;
  localparam logic [7:0] SET_A [8] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h50, 8'h60, 8'h74, 8'hA0};
  localparam logic [7:0] CLR_A [8] = '{8'h04, 8'h14, 8'h24, 8'h44, 8'h54, 8'h64, 8'h70, 8'hA4};
  logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, err;
  logic [7:0] paddr = 8'h00, sa;
  logic [31:0] pwdata = 32'h0, ext = 32'h0, glitch = 32'h0, pa_o = 32'h0, pa_e = 32'h0;
  logic [31:0] pb_o = 32'h0, pb_e = 32'h0, prdata, pin_in, pin_out, pin_oe, periph_in;
  logic [31:0] q, a, b, m, d, rv, old, pu_en;
  // Rule model: the eight set/clear status words in table order, and the driven level.
  int unsigned mdl_reg [8] = '{32'hFFFF_FFFF, 0, 0, 0, 0, 0, 0, 0};
  int unsigned lvl_m = 0;
  int n_fail = 0, check_count = 0;
  pio_ctrl u_dut (.core_clk(core_clk), .rst_b(rst_b), .periph_clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pu_en), .periph_a_out(pa_o), .periph_a_oe(pa_e), .periph_b_out(pb_o),
    .periph_b_oe(pb_e), .periph_in(periph_in), .irq(irq));
  pin_partner u_pins (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext), .glitch(glitch), .pin_in(pin_in));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  function automatic void mdl_write(input logic [7:0] ad, input logic [31:0] wd);
    for (int k = 0; k < 8; k++) begin
      if (ad == SET_A[k]) mdl_reg[k] = mdl_reg[k] | wd;
      if (ad == CLR_A[k]) mdl_reg[k] = mdl_reg[k] & ~wd;
    end
    if (ad == 8'h30) lvl_m = lvl_m | wd;
    if (ad == 8'h34) lvl_m = lvl_m & ~wd;
    if (ad == 8'h38) lvl_m = (lvl_m & ~mdl_reg[7]) | (wd & mdl_reg[7]);
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    if (w) mdl_write(ad, wd);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] ex, input string nm);
    apb(1'b0, ad, 32'h0);
    chk(nm, ex, q);
  endtask
  task automatic idle_rd_pend;
    repeat (6) @(posedge core_clk);
    apb(1'b0, 8'h4C, 32'h0);
  endtask
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hBB2E2EDA));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    {pa_o, pa_e, pb_o, pb_e} <= {$urandom, $urandom, $urandom, $urandom};
    rc(8'h4C, 32'h0, "pending after reset");
    apb(1'b0, 8'h0C, 32'h0);
    chk("reserved error", 32'h1, {31'h0, err});
    for (int i = 0; i < 8; i++) begin
      rv = (i == 0) ? 32'hFFFF_FFFF : 32'h0;
      sa = ((SET_A[i] < CLR_A[i]) ? SET_A[i] : CLR_A[i]) + 8'h08;
      rc(sa, rv, "reset value");
      a = $urandom;
      b = $urandom;
      apb(1'b1, SET_A[i], a);
      apb(1'b1, CLR_A[i], b);
      rc(sa, mdl_reg[i], "status");
      if (i == 5) chk("pull-up enable", ~mdl_reg[5], pu_en);
      apb(1'b1, CLR_A[i], 32'hFFFF_FFFF);
      apb(1'b1, SET_A[i], rv);
    end
    a = $urandom;
    b = $urandom;
    m = $urandom;
    d = $urandom;
    apb(1'b1, 8'h30, a);
    apb(1'b1, 8'h34, b);
    rc(8'h38, lvl_m, "driven level");
    apb(1'b1, 8'hA0, m);
    apb(1'b1, 8'h38, d);
    old = lvl_m;
    rc(8'h38, old, "masked write");
    apb(1'b1, 8'hA4, 32'hFFFF_FFFF);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    repeat (2) @(posedge core_clk);
    rc(8'h3C, old, "pin level driven");
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    repeat (2) @(posedge core_clk);
    rc(8'h3C, pa_o & pa_e, "peripheral level");
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    idle_rd_pend();
    d = $urandom;
    ext <= d;
    repeat (4) @(posedge core_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rc(8'h4C, d, "pending");
    rc(8'h4C, 32'h0, "pending reread");
    m = $urandom;
    apb(1'b1, 8'h40, m);
    b = $urandom;
    ext <= d ^ b;
    repeat (4) @(posedge core_clk);
    chk("irq", {31'h0, |(b & m)}, {31'h0, irq});
    rc(8'h4C, b, "pending masked");
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // The frozen readback matters because software may poll with the clock gated off.
    clk_en <= 1'b0;
    @(posedge core_clk);
    ext <= ~ext;
    repeat (4) @(posedge core_clk);
    rc(8'h3C, d ^ b, "frozen level");
    rc(8'h4C, 32'h0, "no detect clock off");
    clk_en <= 1'b1;
    idle_rd_pend();
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    glitch <= 32'hFFFF_FFFF;
    @(posedge core_clk);
    glitch <= 32'h0;
    repeat (4) @(posedge core_clk);
    rc(8'h3C, ext, "glitch level");
    rc(8'h4C, 32'h0, "glitch pending");
    ext <= ext ^ 32'h1;
    @(posedge core_clk);
    ext <= ext ^ 32'h1;
    repeat (5) @(posedge core_clk);
    rc(8'h4C, 32'h1, "pulse pending");
    end_of_test();
  end
endmodule // test_parallel_io_input_and_register_map
`default_nettype wire
